// ---- logic/recorder_host_command_port.sv ----
// Host-side controller driving the recorder's nibble-wide command port
//
// Contract
// - Rate config code is followed by one nibble: word count and rate selects.
// - Track select code is followed by one nibble: direct mode and track.
// - Bound write code is followed by eight written nibbles, nine in all.
// - Bound read code is followed by eight nibble reads; no status meanwhile.
// - Trigger config code is followed by one nibble: length flag, trigger levels.
// - Busy high during reset and processing; host issues nothing while busy.
// - While active, host issues only stop, pause or start.
// - Busy 16us after each short command nibble; host waits before writing.
// - Bound write: busy 270us after code, 50us after each address nibble.
// - Bound read: host waits 270us after code, 50us after each read.
// - Raw transfer busy 16/270/50us per phase, all scaled by sampling period; port sends only the code, then waits the scaled 16us.
`timescale 1ns/1ns
module recorder_host_command_port (
  input wire logic mclk_i,
  input wire logic resetn_i,
  // User side
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [3:0] cmd_code_i,
  input wire logic [31:0] cmd_data_i,
  output logic cmd_refused_o,
  output logic [3:0] state_flags_o,
  output logic nib_valid_o,
  input wire logic nib_ready_i,
  output logic [3:0] nib_data_o,
  // Device pins
  output logic chip_select_n_o,
  output logic write_strobe_n_o,
  output logic read_strobe_n_o,
  input wire logic [3:0] dq_i,
  output logic [3:0] dq_o,
  output logic dq_oe_o
);
  import recorder_host_pkg::*;

  typedef enum logic [2:0] {S_BOOT, S_IDLE, S_POLL, S_WRITE, S_WAIT, S_READ} state_e;

  state_e st_q;
  logic [2:0] ph_q;
  logic [15:0] wait_q;
  logic [3:0] code_q;
  logic [31:0] data_q;
  logic [3:0] idx_q;
  logic [3:0] total_q;
  logic [10:0] div_q;
  logic [3:0] flags_q;
  logic refused_q;
  logic [3:0] nib_q;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic allowed;
  logic accept;
  logic bound_cmd;
  logic buf_ready;
  logic [12:0] base_cyc;

  // ----------------------------------------------------------------
  // Busy interval scaled by the current sampling divisor
  // ----------------------------------------------------------------
  function automatic logic [15:0] scaled(input logic [12:0] base, input logic [10:0] div);
    logic [23:0] p;
    p = 24'(base) * 24'(div);
    return {1'b0, p[23:DIV_SHIFT]};
  endfunction

  // While active only stop, pause and start may go out
  assign allowed = !flags_q[ACTIVE_BIT] || (cmd_code_i == STOP_CMD) || (cmd_code_i == PAUSE_CMD) ||
                   (cmd_code_i == START_CMD);
  assign accept = (st_q == S_IDLE) && cmd_valid_i;
  assign bound_cmd = (code_q == BOUND_WRITE_CMD) || (code_q == BOUND_READ_CMD);
  assign base_cyc = bound_cmd ? ((idx_q == 4'h0) ? T_LONG_CYC : T_MID_CYC) : T_SHORT_CYC;

  // ----------------------------------------------------------------
  // Pin drive decoded from registered state and phase
  // ----------------------------------------------------------------
  assign cmd_ready_o = (st_q == S_IDLE);
  assign cmd_refused_o = refused_q;
  assign state_flags_o = flags_q;
  assign chip_select_n_o = !((st_q == S_POLL) || (st_q == S_WRITE) || (st_q == S_READ));
  assign write_strobe_n_o = !((st_q == S_WRITE) && (ph_q >= PH_STROBE_LO) && (ph_q < PH_WR_RISE));
  assign read_strobe_n_o = !(((st_q == S_POLL) || (st_q == S_READ)) && (ph_q >= PH_STROBE_LO) &&
                             (ph_q <= PH_SAMPLE));
  assign dq_oe_o = (st_q == S_WRITE);
  assign dq_o = nib_q;

  // Data pins come from outside the clock domain
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end
    else
    begin
      sync1_q <= dq_i;
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: poll busy, write nibble, wait, read address nibbles
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_q <= S_BOOT;
      ph_q <= 3'h0;
      wait_q <= {3'h0, T_BOOT_CYC};
      idx_q <= 4'h0;
      total_q <= LEN_ONE;
    end
    else
    begin
      case (st_q)
        S_BOOT:
        begin
          // Oscillator settling is not known here; the first poll covers it
          if (wait_q == 16'h0)
          begin
            st_q <= S_IDLE;
          end
          else
          begin
            wait_q <= wait_q - 16'h1;
          end
        end
        S_IDLE:
        begin
          if (accept && allowed)
          begin
            idx_q <= 4'h0;
            ph_q <= 3'h0;
            st_q <= S_POLL;
            case (cmd_code_i)
              RATE_CONFIG_CMD, TRACK_SELECT_CMD, TRIGGER_CONFIG_CMD: total_q <= LEN_TWO;
              BOUND_WRITE_CMD, BOUND_READ_CMD: total_q <= LEN_BOUND;
              default: total_q <= LEN_ONE;
            endcase
          end
        end
        S_POLL:
        begin
          ph_q <= ph_q + 3'h1;
          if (ph_q == PH_END)
          begin
            ph_q <= 3'h0;
            if (!flags_q[BUSY_BIT] && (idx_q == total_q))
            begin
              // Closing poll: flags are fresh, so the active check never runs stale
              st_q <= S_IDLE;
            end
            else if (!flags_q[BUSY_BIT])
            begin
              st_q <= S_WRITE;
            end
          end
        end
        S_WRITE, S_READ:
        begin
          ph_q <= ph_q + 3'h1;
          if (ph_q == PH_END)
          begin
            ph_q <= 3'h0;
            idx_q <= idx_q + 4'h1;
            wait_q <= scaled(base_cyc, div_q);
            st_q <= S_WAIT;
          end
        end
        S_WAIT:
        begin
          if (wait_q != 16'h0)
          begin
            wait_q <= wait_q - 16'h1;
          end
          else if (idx_q == total_q)
          begin
            // One more poll before idle refreshes state_flags
            st_q <= S_POLL;
          end
          else if (code_q == BOUND_READ_CMD)
          begin
            // Busy flag is not readable here, so timing and read buffer space pace reads
            if (buf_ready)
            begin
              st_q <= S_READ;
            end
          end
          else
          begin
            st_q <= S_POLL;
          end
        end
        default:
        begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Command, data shift and outgoing nibble
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      code_q <= IDLE_CMD;
      data_q <= 32'h0;
      nib_q <= 4'h0;
      div_q <= DIV_RESET;
    end
    else
    begin
      if (accept && allowed)
      begin
        code_q <= cmd_code_i;
        data_q <= cmd_data_i;
      end
      if ((st_q == S_POLL) && (ph_q == PH_END))
      begin
        nib_q <= (idx_q == 4'h0) ? code_q : data_q[3:0];
      end
      if ((st_q == S_WRITE) && (ph_q == PH_END) && (idx_q != 4'h0))
      begin
        data_q <= {4'h0, data_q[31:4]};
        if (code_q == RATE_CONFIG_CMD)
        begin
          // Later busy times follow the newly chosen sampling rate
          case (nib_q[1:0])
            2'h0: div_q <= DIV_RATE0;
            2'h1: div_q <= DIV_RATE1;
            2'h2: div_q <= DIV_RATE2;
            default: div_q <= DIV_RATE3;
          endcase
        end
      end
    end
  end

  // Status capture on each poll, and refusal pulse
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      flags_q <= FLAGS_RESET;
      refused_q <= 1'b0;
    end
    else
    begin
      refused_q <= accept && !allowed;
      if ((st_q == S_POLL) && (ph_q == PH_SAMPLE))
      begin
        flags_q <= sync2_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Address nibbles read back go through the two-entry buffer
  // ----------------------------------------------------------------
  nibble_buffer #(
    .WIDTH(4),
    .DEPTH(2)
  ) u_read_buf (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .in_valid_i((st_q == S_READ) && (ph_q == PH_SAMPLE)),
    .in_ready_o(buf_ready),
    .in_data_i(sync2_q),
    .out_valid_o(nib_valid_o),
    .out_ready_i(nib_ready_i),
    .out_data_o(nib_data_o)
  );

  // ----------------------------------------------------------------
  // Checks: helper counters for gaps and nibbles per command
  // ----------------------------------------------------------------
  logic [15:0] gap_q;
  logic [3:0] strobes_q;

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      gap_q <= 16'hffff;
      strobes_q <= 4'h0;
    end
    else
    begin
      if (((st_q == S_WRITE) || (st_q == S_READ)) && (ph_q == PH_WR_RISE))
      begin
        gap_q <= 16'h0;
        strobes_q <= strobes_q + 4'h1;
      end
      else if (gap_q != 16'hffff)
      begin
        gap_q <= gap_q + 16'h1;
      end
      if (accept && allowed)
      begin
        strobes_q <= 4'h0;
      end
    end
  end

  strobe_excl_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !(!write_strobe_n_o && !read_strobe_n_o) && (write_strobe_n_o || !chip_select_n_o))
    else $error("strobes overlap or lack chip select");
  busy_clear_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    $fell(write_strobe_n_o) |-> !flags_q[BUSY_BIT] && $past(st_q, 2) == S_POLL)
    else $error("write issued without a clear busy poll");
  short_gap_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    $fell(write_strobe_n_o) |-> gap_q >= 16'(T_SHORT_CYC))
    else $error("write came too soon after previous nibble");
  bound_gap_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    $fell(write_strobe_n_o) && code_q == BOUND_WRITE_CMD && idx_q == 4'h1 |-> gap_q >= 16'(T_LONG_CYC))
    else $error("first address nibble too soon after bound write code");
  read_gap_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    $fell(read_strobe_n_o) && st_q == S_READ |-> gap_q >= 16'(T_MID_CYC))
    else $error("address read too soon");
  active_refuse_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    accept && flags_q[ACTIVE_BIT] && cmd_code_i != STOP_CMD && cmd_code_i != PAUSE_CMD &&
    cmd_code_i != START_CMD |=> cmd_refused_o && st_q == S_IDLE)
    else $error("disallowed command taken while active");
  bound_count_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    st_q == S_IDLE && $past(st_q) == S_POLL && bound_cmd |-> strobes_q == 4'h9)
    else $error("bound command did not move nine nibbles");
  pair_count_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    st_q == S_IDLE && $past(st_q) == S_POLL && (code_q == RATE_CONFIG_CMD || code_q == TRACK_SELECT_CMD ||
    code_q == TRIGGER_CONFIG_CMD) |-> strobes_q == 4'h2)
    else $error("two-nibble command wrong length");

  bound_read_c: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    st_q == S_IDLE && $past(st_q) == S_POLL && code_q == BOUND_READ_CMD);
  busy_repoll_c: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    st_q == S_POLL && ph_q == PH_END && flags_q[BUSY_BIT]);
  refusal_c: cover property (@(posedge mclk_i) disable iff (!resetn_i) cmd_refused_o);
  buffer_stall_c: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    st_q == S_WAIT && wait_q == 16'h0 && !buf_ready);

endmodule

// ---- logic/recorder_host_pkg.sv ----
// Constants shared by the recorder host command port, its device model and bench
package recorder_host_pkg;

  // ----------------------------------------------------------------
  // Clock and busy intervals
  // ----------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int T_BOOT_NS = 125000;
  localparam int T_SHORT_NS = 16000;
  localparam int T_MID_NS = 50000;
  localparam int T_LONG_NS = 270000;
  // Least times, so round up to whole cycles
  localparam logic [12:0] T_BOOT_CYC = 13'((T_BOOT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [12:0] T_SHORT_CYC = 13'((T_SHORT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [12:0] T_MID_CYC = 13'((T_MID_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [12:0] T_LONG_CYC = 13'((T_LONG_NS + CLK_NS - 1) / CLK_NS);

  // ----------------------------------------------------------------
  // Sampling divisors; busy times scale with the sampling period
  // ----------------------------------------------------------------
  localparam logic [10:0] DIV_RATE0 = 11'h400;
  localparam logic [10:0] DIV_RATE1 = 11'h300;
  localparam logic [10:0] DIV_RATE2 = 11'h280;
  localparam logic [10:0] DIV_RATE3 = 11'h200;
  localparam logic [10:0] DIV_RESET = DIV_RATE0;
  localparam int DIV_SHIFT = 9;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [3:0] IDLE_CMD = 4'h0;
  localparam logic [3:0] PAUSE_CMD = 4'h1;
  localparam logic [3:0] PLAYBACK_MODE_CMD = 4'h2;
  localparam logic [3:0] CAPTURE_MODE_CMD = 4'h3;
  localparam logic [3:0] START_CMD = 4'h4;
  localparam logic [3:0] STOP_CMD = 4'h5;
  localparam logic [3:0] RATE_CONFIG_CMD = 4'h6;
  localparam logic [3:0] TRACK_SELECT_CMD = 4'h7;
  localparam logic [3:0] BOUND_WRITE_CMD = 4'h8;
  localparam logic [3:0] BOUND_READ_CMD = 4'h9;
  localparam logic [3:0] RAW_TRANSFER_CMD = 4'ha;
  localparam logic [3:0] HOST_STREAM_CMD = 4'hb;
  localparam logic [3:0] TRIGGER_CONFIG_CMD = 4'hc;

  // Nibble totals, command code included
  localparam logic [3:0] LEN_ONE = 4'h1;
  localparam logic [3:0] LEN_TWO = 4'h2;
  localparam logic [3:0] LEN_BOUND = 4'h9;

  // ----------------------------------------------------------------
  // state_flags bit positions and bus phases
  // ----------------------------------------------------------------
  localparam int BUSY_BIT = 0;
  localparam int ACTIVE_BIT = 1;
  localparam int WAITING_BIT = 2;
  localparam int FULL_BIT = 3;
  localparam logic [3:0] FLAGS_RESET = 4'h1;
  localparam logic [2:0] PH_STROBE_LO = 3'h1;
  localparam logic [2:0] PH_WR_RISE = 3'h5;
  localparam logic [2:0] PH_SAMPLE = 3'h5;
  localparam logic [2:0] PH_END = 3'h6;

endpackage

// ---- logic/nibble_buffer.sv ----
// Small valid/ready buffer holding nibbles read back from the device
`timescale 1ns/1ns
module nibble_buffer #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 2
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic push;
  logic pop;

  // ----------------------------------------------------------------
  // Flags come straight from the count, so full and empty are exact
  // ----------------------------------------------------------------
  assign in_ready_o = (count_q != CW'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign out_data_o = mem_q[rd_ptr_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage written only on a push
  always_ff @(posedge mclk_i)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  // Pointers wrap at the depth, not at a power of two
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop)
      begin
        count_q <= count_q + 1'b1;
      end
      else if (pop && !push)
      begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

// ---- tb/recorder_device_model.sv ----
// Behavioural model of the recorder device behind the nibble command port
`timescale 1ns/1ns
module recorder_device_model
  import recorder_host_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic chip_select_n_i,
  input wire logic write_strobe_n_i,
  input wire logic read_strobe_n_i,
  input wire logic [3:0] dq_i,
  input wire logic slow_i,
  input wire logic mem_end_i,
  output logic [3:0] dq_o,
  output logic [7:0] viol_o
);
  localparam int SLOW_CYC = 300;
  logic wr_lo, rd_lo, wr_d1, rd_d1, rd_mode_q, rec_q, active_q, waiting_q, full_q;
  logic [3:0] code_q, left_q, rate_q, track_q, trig_q, rd_idx_q, last_q;
  logic [3:0] bound_q [8];
  int busy_cnt, guard_cnt, extra;

  // Busy spans stretch with the sampling period
  function automatic int span(input logic [12:0] base, input logic [1:0] sel);
    logic [10:0] div;
    div = (sel == 2'd0) ? DIV_RATE0 : (sel == 2'd1) ? DIV_RATE1 : (sel == 2'd2) ? DIV_RATE2 : DIV_RATE3;
    return (int'(base) * int'(div)) >>> DIV_SHIFT;
  endfunction

  assign wr_lo = !chip_select_n_i && !write_strobe_n_i;
  assign rd_lo = !chip_select_n_i && !read_strobe_n_i;
  assign extra = slow_i ? SLOW_CYC : 0;

  // ----------------------------------------------------------------
  // Command decode, flags and timing watch
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      busy_cnt <= int'(T_BOOT_CYC) + SLOW_CYC;
      guard_cnt <= 0;
      {wr_d1, rd_d1, rd_mode_q, rec_q, active_q, waiting_q, full_q} <= '0;
      {code_q, left_q, rate_q, track_q, trig_q, rd_idx_q, last_q} <= '0;
      viol_o <= '0;
    end
    else
    begin
      wr_d1 <= wr_lo;
      rd_d1 <= rd_lo;
      if (rd_lo) last_q <= dq_o;
      if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
      if (guard_cnt > 0) guard_cnt <= guard_cnt - 1;
      // Flex recording ran into the end of memory
      if (mem_end_i && active_q && rate_q[3:2] == 2'b11 && track_q[3])
      begin
        full_q <= 1'b1;
        active_q <= 1'b0;
      end
      // Host has no busy flag here, so it must keep the quiet span itself
      if (rd_lo && !rd_d1 && guard_cnt > 0) viol_o <= viol_o + 8'h01;
      if (rd_d1 && !rd_lo && rd_mode_q)
      begin
        rd_idx_q <= rd_idx_q + 4'h1;
        guard_cnt <= span(T_MID_CYC, rate_q[1:0]);
        if (rd_idx_q == 4'h7) rd_mode_q <= 1'b0;
      end
      if (wr_d1 && write_strobe_n_i && !chip_select_n_i)
      begin
        if (busy_cnt > 0 || guard_cnt > 0 || rd_mode_q) viol_o <= viol_o + 8'h01;
        if (left_q != 4'h0)
        begin
          left_q <= left_q - 4'h1;
          busy_cnt <= span((code_q == BOUND_WRITE_CMD) ? T_MID_CYC : T_SHORT_CYC, rate_q[1:0]) + extra;
          case (code_q)
            RATE_CONFIG_CMD: rate_q <= dq_i;
            TRACK_SELECT_CMD: track_q <= dq_i;
            TRIGGER_CONFIG_CMD: trig_q <= dq_i;
            BOUND_WRITE_CMD: if (!track_q[3]) bound_q[3'(4'h8 - left_q)] <= dq_i;
            default: ;
          endcase
        end
        else
        begin
          code_q <= dq_i;
          busy_cnt <= span(T_SHORT_CYC, rate_q[1:0]) + extra;
          case (dq_i)
            PAUSE_CMD: if (active_q) waiting_q <= 1'b1;
            PLAYBACK_MODE_CMD: {rec_q, full_q} <= 2'b00;
            CAPTURE_MODE_CMD: {rec_q, full_q} <= 2'b10;
            START_CMD:
            begin
              full_q <= 1'b0;
              if (waiting_q && active_q) waiting_q <= 1'b0;
              else if (rec_q && trig_q[1:0] != 2'b00) waiting_q <= 1'b1;
              else active_q <= 1'b1;
            end
            STOP_CMD: {active_q, waiting_q} <= 2'b00;
            RATE_CONFIG_CMD, TRACK_SELECT_CMD, TRIGGER_CONFIG_CMD: left_q <= 4'h1;
            BOUND_WRITE_CMD:
            begin
              left_q <= 4'h8;
              busy_cnt <= span(T_LONG_CYC, rate_q[1:0]) + extra;
            end
            BOUND_READ_CMD:
            begin
              rd_mode_q <= 1'b1;
              rd_idx_q <= 4'h0;
              busy_cnt <= 0;
              guard_cnt <= span(T_LONG_CYC, rate_q[1:0]);
            end
            default: ;
          endcase
        end
      end
    end
  end

  // Released pins show the inverse of the last value, never a stale copy
  always_comb
  begin
    if (!rd_lo) dq_o = ~last_q;
    else if (rd_mode_q) dq_o = bound_q[rd_idx_q[2:0]];
    else dq_o = {full_q, waiting_q, active_q, (busy_cnt != 0)};
  end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the recorder host command port with a device model
`timescale 1ns/1ns
module tb_top;
  import recorder_host_pkg::*;
  localparam logic [31:0] BOUNDS = 32'h7a3c_e158;
  logic mclk_i, resetn_i, cmd_valid_i, cmd_ready_o, cmd_refused_o, nib_valid_o, nib_ready_i;
  logic slow, mem_end, cs_n, wr_n, rd_n, host_oe;
  logic [3:0] cmd_code_i, state_flags_o, nib_data_o, host_dq, dev_dq, dq_wire;
  logic [31:0] cmd_data_i;
  logic [7:0] viol;
  logic [3:0] one_codes [3] = '{IDLE_CMD, RAW_TRANSFER_CMD, HOST_STREAM_CMD};
  int fail_count = 0;
  int n_tests = 0;

  // Pin level is whoever drives it
  assign dq_wire = host_oe ? host_dq : dev_dq;

  recorder_host_command_port i_recorder_host_command_port (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .cmd_code_i(cmd_code_i), .cmd_data_i(cmd_data_i), .cmd_refused_o(cmd_refused_o),
    .state_flags_o(state_flags_o), .nib_valid_o(nib_valid_o), .nib_ready_i(nib_ready_i),
    .nib_data_o(nib_data_o), .chip_select_n_o(cs_n), .write_strobe_n_o(wr_n),
    .read_strobe_n_o(rd_n), .dq_i(dq_wire), .dq_o(host_dq), .dq_oe_o(host_oe));

  recorder_device_model i_recorder_device_model (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .chip_select_n_i(cs_n), .write_strobe_n_i(wr_n),
    .read_strobe_n_i(rd_n), .dq_i(dq_wire), .slow_i(slow), .mem_end_i(mem_end),
    .dq_o(dev_dq), .viol_o(viol));

  // ----------------------------------------------------------------
  // Clock, checks and user-side access tasks
  // ----------------------------------------------------------------
  initial
  begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wait_ready;
    for (int i = 0; i < 30000 && cmd_ready_o !== 1'b1; i++)
      @(negedge mclk_i);
    compare(32'(cmd_ready_o), 32'h1);
  endtask

  // One user command, whole sequence until the port is idle again
  task automatic do_cmd(input logic [3:0] code, input logic [31:0] data);
    wait_ready();
    cmd_code_i = code;
    cmd_data_i = data;
    cmd_valid_i = 1'b1;
    @(negedge mclk_i);
    cmd_valid_i = 1'b0;
    wait_ready();
  endtask

  // Drain read-back nibbles, optionally after the reader has stalled
  task automatic pop_all(input logic [31:0] data, input int stall);
    nib_ready_i = 1'b0;
    repeat (stall) @(negedge mclk_i);
    if (stall > 0) compare(32'(i_recorder_device_model.rd_idx_q), 32'h2);
    nib_ready_i = 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      for (int i = 0; i < 30000 && nib_valid_o !== 1'b1; i++)
        @(negedge mclk_i);
      compare(32'(nib_data_o), 32'(data[4*k +: 4]));
      @(negedge mclk_i);
    end
    nib_ready_i = 1'b0;
  endtask

  task automatic flags_after(input logic [3:0] code, input logic [3:0] exp);
    do_cmd(code, 32'h0);
    compare(32'(state_flags_o), 32'(exp));
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    {cmd_valid_i, nib_ready_i, mem_end, resetn_i} = '0;
    cmd_code_i = 4'h0;
    cmd_data_i = 32'h0;
    slow = 1'b1;
    repeat (20) @(negedge mclk_i);
    compare(32'(state_flags_o), 32'(FLAGS_RESET));
    compare(32'(cmd_ready_o), 32'h0);
    resetn_i = 1'b1;
    foreach (one_codes[j])
    begin
      slow = j[0];
      flags_after(one_codes[j], 4'h0);
    end
    $display("test done: boot and one-nibble codes");
    do_cmd(BOUND_WRITE_CMD, BOUNDS);
    fork
      do_cmd(BOUND_READ_CMD, 32'h0);
      pop_all(BOUNDS, 0);
    join
    $display("test done: bounds at reset rate");
    do_cmd(RATE_CONFIG_CMD, 32'hf);
    compare(32'(i_recorder_device_model.rate_q), 32'hf);
    do_cmd(TRIGGER_CONFIG_CMD, 32'h5);
    compare(32'(i_recorder_device_model.trig_q), 32'h5);
    do_cmd(TRACK_SELECT_CMD, 32'hb);
    compare(32'(i_recorder_device_model.track_q), 32'hb);
    fork
      do_cmd(BOUND_READ_CMD, 32'h0);
      pop_all(BOUNDS, 6000);
    join
    $display("test done: configuration and stalled read-back");
    flags_after(CAPTURE_MODE_CMD, 4'h0);
    flags_after(START_CMD, 4'h4);
    flags_after(STOP_CMD, 4'h0);
    do_cmd(TRIGGER_CONFIG_CMD, 32'h0);
    flags_after(CAPTURE_MODE_CMD, 4'h0);
    flags_after(START_CMD, 4'h2);
    wait_ready();
    cmd_code_i = PLAYBACK_MODE_CMD;
    cmd_valid_i = 1'b1;
    @(negedge mclk_i);
    cmd_valid_i = 1'b0;
    compare(32'(cmd_refused_o), 32'h1);
    compare(32'(cmd_ready_o), 32'h1);
    flags_after(PAUSE_CMD, 4'h6);
    flags_after(START_CMD, 4'h2);
    mem_end = 1'b1;
    @(negedge mclk_i);
    mem_end = 1'b0;
    flags_after(STOP_CMD, 4'h8);
    flags_after(PLAYBACK_MODE_CMD, 4'h0);
    compare(32'(viol), 32'h0);
    $display("test done: record, pause, refusal and full flag");
    print_verdict();
  end

  // Watchdog: about twice the expected run of some 45000 cycles
  initial
  begin
    #(100 * 95000);
    fail_count++;
    print_verdict();
  end
endmodule
